// ==== vcsp_serial_port.sv ====
`timescale 1ns/10ps
// Function
// - Companded mode moves one 8-bit word per frame
// - Linear word is 16 bits, 13 sample first
// - Static pin chooses companded or linear coding
// - Fixed mode: master clock shifts both directions
// - Variable mode: separate transmit and receive clocks
// - Receive clock pin held high selects fixed
// - Receive data sampled on falling receive-clock edges
// - Transmit data launched on rising transmit-clock edges
// - Select pin low means linear, high companded
// - Five low frames standby; five high test
// - Shared pin: slot strobe fixed, clock variable
module vcsp_serial_port
  import vcsp_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_MCLKS  // Master clocks per frame
) (
  // System
  input  wire logic              CLK,
  input  wire logic              SRST,
  // Serial pins
  input  wire logic              MCLK,
  input  wire logic              RX_BIT_CLOCK,
  input  wire logic              TX_BIT_CLOCK_I,
  output logic                   TX_SLOT_STROBE_N_O,
  output logic                   TX_SLOT_STROBE_N_OE,
  input  wire logic              RX_FRAME_SYNC,
  input  wire logic              TX_FRAME_SYNC,
  input  wire logic              LINEAR_SELECT_N,
  input  wire logic              DIN,
  output logic                   DOUT,
  output logic                   DOUT_OE,
  // Converter side, transmit
  input  wire logic [WORD_W-1:0] TX_WORD,
  output logic                   TX_TAKE,
  // Converter side, receive
  output logic [WORD_W-1:0]      RX_WORD,
  output logic                   RX_VALID,
  // Status
  output logic                   LINEAR_MODE,
  output logic                   FIXED_MODE,
  output logic                   RX_STANDBY,
  output logic                   TX_STANDBY,
  output logic                   TEST_MODE
);

  localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_LEN - 1);  // Last frame count
  localparam logic [FIX_W-1:0]   FIX_FULL   = FIX_W'(FIX_EDGES);        // Detector saturation

  logic [SY_N-1:0]   sync1_r;        // First synchroniser stage, read only by stage two
  logic [SY_N-1:0]   sync2_r;        // Synchronised pins
  logic [SY_N-1:0]   prev_r;         // Previous synchronised value, for edges
  logic              mclk_rise;      // Master clock rising edge
  logic              mclk_fall;      // Master clock falling edge
  logic              tx_rise;        // Selected transmit shift edge
  logic              rx_fall;        // Selected receive sample edge
  logic              linear;         // Linear coding selected
  logic [FIX_W-1:0]  fix_cnt_r;      // Edges with receive clock pin high
  logic              fixed_r;        // Fixed-data-rate mode
  vcsp_state_t       tx_st_r;        // Transmit shifter state
  logic [WORD_W-1:0] tx_sh_r;        // Transmit shift register
  logic [CNT_W-1:0]  tx_cnt_r;       // Transmit bit index
  logic [CNT_W-1:0]  tx_last_r;      // Transmit last bit index, latched per word
  logic              tx_fs_prev_r;   // Frame sync at previous transmit edge
  logic              dout_r;         // Serial output bit
  logic              dout_oe_r;      // Serial output driven
  logic              tx_start;       // Word start on this edge
  vcsp_state_t       rx_st_r;        // Receive shifter state
  logic [WORD_W-1:0] rx_sh_r;        // Receive shift register
  logic [CNT_W-1:0]  rx_cnt_r;       // Receive bit index
  logic [CNT_W-1:0]  rx_last_r;      // Receive last bit index, latched per word
  logic              rx_fs_prev_r;   // Frame sync at previous receive edge
  logic [WORD_W-1:0] rx_word_r;      // Last complete receive word
  logic              rx_valid_r;     // One-cycle word-ready pulse
  logic [FRAME_W-1:0] fr_cnt_r;      // Master clocks within the frame
  logic              frame_end;      // Last master clock of a frame
  logic [1:0]        fs_now;         // Synchronised frame syncs per channel
  logic [1:0]        seen_hi_r;      // Sync seen high this frame
  logic [1:0]        seen_lo_r;      // Sync seen low this frame
  logic [2:0]        lo_frames_r [2];  // Consecutive all-low frames
  logic [2:0]        hi_frames_r [2];  // Consecutive all-high frames

  // Two-flop synchronisers for every pin; edges come from stage two only
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= {LINEAR_SELECT_N, DIN, TX_FRAME_SYNC, RX_FRAME_SYNC,
                  TX_BIT_CLOCK_I, RX_BIT_CLOCK, MCLK};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Edge finding and clock selection
  assign mclk_rise = sync2_r[SY_MCLK] & ~prev_r[SY_MCLK];
  assign mclk_fall = ~sync2_r[SY_MCLK] & prev_r[SY_MCLK];
  // Fixed mode shifts on the master clock; variable on the bit clocks
  assign tx_rise   = fixed_r ? mclk_rise
                             : (sync2_r[SY_TXCLK] & ~prev_r[SY_TXCLK]);
  assign rx_fall   = fixed_r ? mclk_fall
                             : (~sync2_r[SY_RXCLK] & prev_r[SY_RXCLK]);
  // Active-low select: low picks linear coding
  assign linear    = ~sync2_r[SY_LINEAR_SELECT_N];
  assign fs_now    = {sync2_r[SY_TXFS], sync2_r[SY_RXFS]};

  // Fixed-rate detector: the pin tied high never toggles, a real clock does.
  // Any low sample drops back to variable mode at once.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fix_cnt_r <= '0;
      fixed_r   <= 1'b0;
    end else if (!sync2_r[SY_RXCLK]) begin
      fix_cnt_r <= '0;
      fixed_r   <= 1'b0;
    end else if (mclk_rise && fix_cnt_r != FIX_FULL) begin
      fix_cnt_r <= FIX_W'(fix_cnt_r + 1'b1);
      fixed_r   <= (FIX_W'(fix_cnt_r + 1'b1) == FIX_FULL);
    end
  end

  // Word start: first transmit edge after the sync goes high
  assign tx_start = tx_rise && (tx_st_r == VCSP_IDLE) && fs_now[CH_TX] && !tx_fs_prev_r;

  // Transmit shifter: MSB out on the start edge, one bit per rising edge.
  // Companded words sit in the low byte of the input and go out as 8 bits.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tx_st_r      <= VCSP_IDLE;
      tx_sh_r      <= '0;
      tx_cnt_r     <= CNT_ZERO;
      tx_last_r    <= COMP_LAST;
      tx_fs_prev_r <= 1'b0;
      dout_r       <= 1'b0;
      dout_oe_r    <= 1'b0;
    end else if (tx_rise) begin
      tx_fs_prev_r <= fs_now[CH_TX];
      unique case (tx_st_r)
        VCSP_IDLE: begin
          if (tx_start) begin
            // Coding latched per word so a pin change cannot split a word
            tx_last_r <= vcsp_last_bit(linear);
            if (linear) begin
              dout_r  <= TX_WORD[WORD_W-1];
              tx_sh_r <= {TX_WORD[WORD_W-2:0], 1'b0};
            end else begin
              dout_r  <= TX_WORD[COMP_W-1];
              tx_sh_r <= {TX_WORD[COMP_W-2:0], {(WORD_W-COMP_W+1){1'b0}}};
            end
            tx_cnt_r  <= CNT_ZERO;
            dout_oe_r <= 1'b1;
            tx_st_r   <= VCSP_SHIFT;
          end
        end
        VCSP_SHIFT: begin
          if (tx_cnt_r == tx_last_r) begin
            // Last bit has had its full period; release the line
            dout_oe_r <= 1'b0;
            tx_st_r   <= VCSP_IDLE;
          end else begin
            dout_r   <= tx_sh_r[WORD_W-1];
            tx_sh_r  <= {tx_sh_r[WORD_W-2:0], 1'b0};
            tx_cnt_r <= CNT_W'(tx_cnt_r + CNT_ONE);
          end
        end
      endcase
    end
  end

  // Receive shifter: first bit on the first falling edge after the sync rises
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rx_st_r      <= VCSP_IDLE;
      rx_sh_r      <= '0;
      rx_cnt_r     <= CNT_ZERO;
      rx_last_r    <= COMP_LAST;
      rx_fs_prev_r <= 1'b0;
      rx_word_r    <= '0;
      rx_valid_r   <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (rx_fall) begin
        rx_fs_prev_r <= fs_now[CH_RX];
        unique case (rx_st_r)
          VCSP_IDLE: begin
            if (fs_now[CH_RX] && !rx_fs_prev_r) begin
              rx_last_r <= vcsp_last_bit(linear);
              rx_sh_r   <= {{(WORD_W-1){1'b0}}, sync2_r[SY_DIN]};
              rx_cnt_r  <= CNT_ZERO;
              rx_st_r   <= VCSP_SHIFT;
            end
          end
          VCSP_SHIFT: begin
            // Shift in MSB first; companded words land in the low byte
            rx_sh_r  <= {rx_sh_r[WORD_W-2:0], sync2_r[SY_DIN]};
            rx_cnt_r <= CNT_W'(rx_cnt_r + CNT_ONE);
            if (CNT_W'(rx_cnt_r + CNT_ONE) == rx_last_r) begin
              rx_word_r  <= {rx_sh_r[WORD_W-2:0], sync2_r[SY_DIN]};
              rx_valid_r <= 1'b1;
              rx_st_r    <= VCSP_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Frame timebase from the master clock, used by the sync supervisors
  assign frame_end = mclk_rise && (fr_cnt_r == FRAME_LAST);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      fr_cnt_r <= '0;
    end else if (mclk_rise) begin
      fr_cnt_r <= frame_end ? '0 : FRAME_W'(fr_cnt_r + 1'b1);
    end
  end

  // Sync supervisors: a frame with the sync never high counts toward
  // standby, one never low toward test. Counts saturate at five.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      seen_hi_r <= '0;
      seen_lo_r <= '0;
      for (int c = 0; c < 2; c++) begin
        lo_frames_r[c] <= FR_ZERO;
        hi_frames_r[c] <= FR_ZERO;
      end
    end else if (mclk_rise) begin
      for (int c = 0; c < 2; c++) begin
        if (frame_end) begin
          // The current sample belongs to the closing frame
          lo_frames_r[c] <= (seen_hi_r[c] | fs_now[c]) ? FR_ZERO
                                                       : vcsp_sat_inc(lo_frames_r[c]);
          hi_frames_r[c] <= (seen_lo_r[c] | ~fs_now[c]) ? FR_ZERO
                                                        : vcsp_sat_inc(hi_frames_r[c]);
          seen_hi_r[c]   <= 1'b0;
          seen_lo_r[c]   <= 1'b0;
        end else begin
          seen_hi_r[c]   <= seen_hi_r[c] | fs_now[c];
          seen_lo_r[c]   <= seen_lo_r[c] | ~fs_now[c];
        end
      end
    end
  end

  // Outputs
  assign DOUT                = dout_r;
  assign DOUT_OE             = dout_oe_r;
  // Open-drain strobe: only ever pulls low, and only in fixed mode
  assign TX_SLOT_STROBE_N_O  = 1'b0;
  assign TX_SLOT_STROBE_N_OE = fixed_r && (tx_st_r == VCSP_SHIFT);
  assign TX_TAKE             = tx_start;
  assign RX_WORD             = rx_word_r;
  assign RX_VALID            = rx_valid_r;
  assign LINEAR_MODE         = linear;
  assign FIXED_MODE          = fixed_r;
  assign RX_STANDBY          = (lo_frames_r[CH_RX] == IDLE_FRAMES);
  assign TX_STANDBY          = (lo_frames_r[CH_TX] == IDLE_FRAMES);
  assign TEST_MODE           = (hi_frames_r[CH_RX] == IDLE_FRAMES) ||
                               (hi_frames_r[CH_TX] == IDLE_FRAMES);

endmodule // vcsp_serial_port

// ==== vcsp_pkg.sv ====
package vcsp_pkg;

  // Word geometry
  localparam int          WORD_W      = 16;        // Widest serial word (linear)
  localparam int          COMP_W      = 8;         // Companded word width
  localparam int          SAMPLE_W    = 13;        // Sample bits inside a linear word
  localparam int          EXTRA_W     = 3;         // Gain or padding bits after the sample
  localparam int          CNT_W       = 5;         // Bit counter width
  localparam logic [4:0]  COMP_LAST   = 5'h07;     // Index of last bit, companded
  localparam logic [4:0]  LIN_LAST    = 5'h0F;     // Index of last bit, linear
  localparam logic [4:0]  CNT_ZERO    = 5'h00;     // Bit counter start value
  localparam logic [4:0]  CNT_ONE     = 5'h01;     // Bit counter step

  // Frame supervision
  localparam int          FRAME_MCLKS = 256;       // Master clocks per frame (2.048 MHz / 8 kHz)
  localparam int          FRAME_W     = 8;         // Frame counter width
  localparam logic [2:0]  IDLE_FRAMES = 3'h5;      // Frames of a stuck sync before it counts
  localparam logic [2:0]  FR_ZERO     = 3'h0;      // Stuck-frame counter start
  localparam logic [2:0]  FR_ONE      = 3'h1;      // Stuck-frame counter step

  // Fixed-rate detection: receive clock pin seen high on this many master edges
  localparam int          FIX_EDGES   = 16;
  localparam int          FIX_W       = 5;

  // Synchroniser lanes
  localparam int          SY_MCLK     = 0;
  localparam int          SY_RXCLK    = 1;
  localparam int          SY_TXCLK    = 2;
  localparam int          SY_RXFS     = 3;
  localparam int          SY_TXFS     = 4;
  localparam int          SY_DIN      = 5;
  localparam int          SY_LINEAR_SELECT_N   = 6;
  localparam int          SY_N        = 7;

  // Channel index for the frame-sync supervisors
  localparam int          CH_RX       = 0;
  localparam int          CH_TX       = 1;

  // Shifter state
  typedef enum logic [1:0] {
    VCSP_IDLE  = 2'b01,
    VCSP_SHIFT = 2'b10
  } vcsp_state_t;

  // Last bit index for the selected coding
  function automatic logic [4:0] vcsp_last_bit(input logic linear);
    return linear ? LIN_LAST : COMP_LAST;
  endfunction

  // Saturating stuck-frame counter step
  function automatic logic [2:0] vcsp_sat_inc(input logic [2:0] cnt);
    return (cnt == IDLE_FRAMES) ? cnt : 3'(cnt + FR_ONE);
  endfunction

endpackage

// ==== vcsp_serial_port_sva.sv ====
`timescale 1ns/10ps
module vcsp_serial_port_sva
  import vcsp_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_MCLKS  // Master clocks per frame
) (
  // System
  input wire logic              CLK,
  input wire logic              SRST,
  // Pins
  input wire logic              MCLK,
  input wire logic              RX_BIT_CLOCK,
  input wire logic              RX_FRAME_SYNC,
  input wire logic              TX_FRAME_SYNC,
  input wire logic              LINEAR_SELECT_N,
  input wire logic              DOUT,
  input wire logic              DOUT_OE,
  input wire logic              TX_SLOT_STROBE_N_O,
  input wire logic              TX_SLOT_STROBE_N_OE,
  // Converter side and status
  input wire logic [WORD_W-1:0] TX_WORD,
  input wire logic              TX_TAKE,
  input wire logic [WORD_W-1:0] RX_WORD,
  input wire logic              RX_VALID,
  input wire logic              LINEAR_MODE,
  input wire logic              FIXED_MODE,
  input wire logic              RX_STANDBY,
  input wire logic              TEST_MODE
);
  localparam int MIN_RISES = 5 * FRAME_LEN - 2;  // Five frames, less sync skew
  logic        mclk_q;    // Master clock one cycle back
  logic        lead_bit;  // Leading bit of the word on offer
  logic [15:0] lo_cnt;    // Master rises with receive sync low
  logic [15:0] hi_cnt;    // Master rises with a sync high
  // Saturating counts, so a long idle never wraps to zero
  always_ff @(posedge CLK) begin
    mclk_q   <= MCLK;
    lead_bit <= LINEAR_MODE ? TX_WORD[15] : TX_WORD[7];
    if (SRST || RX_FRAME_SYNC) lo_cnt <= '0;
    else if (MCLK && !mclk_q && !(&lo_cnt)) lo_cnt <= lo_cnt + 16'h0001;
    if (SRST || !(RX_FRAME_SYNC || TX_FRAME_SYNC)) hi_cnt <= '0;
    else if (MCLK && !mclk_q && !(&hi_cnt)) hi_cnt <= hi_cnt + 16'h0001;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  chk_first_bit_out: assert property (TX_TAKE |=> DOUT_OE && DOUT == lead_bit)
    else $error("first transmit bit wrong");
  chk_strobe_fixed: assert property (TX_SLOT_STROBE_N_OE |-> FIXED_MODE && DOUT_OE)
    else $error("slot strobe outside a fixed-rate word");
  chk_strobe_low: assert property (TX_SLOT_STROBE_N_O == 1'b0)
    else $error("slot strobe drives high");
  chk_compand_byte: assert property (RX_VALID && !LINEAR_MODE |-> RX_WORD[15:8] == 8'h00)
    else $error("companded word not right aligned");
  chk_standby_entry: assert property ($rose(RX_STANDBY) |-> lo_cnt >= MIN_RISES)
    else $error("standby entered too early");
  chk_test_entry: assert property ($rose(TEST_MODE) |-> hi_cnt >= MIN_RISES)
    else $error("test condition entered too early");
  chk_coding_sel: assert property ($changed(LINEAR_SELECT_N) |-> ##[1:4] LINEAR_MODE != LINEAR_SELECT_N)
    else $error("coding does not follow select pin");
  chk_variable_rate: assert property (!RX_BIT_CLOCK |-> ##[1:4] !FIXED_MODE)
    else $error("fixed rate kept with receive clock low");
endmodule // vcsp_serial_port_sva
bind vcsp_serial_port vcsp_serial_port_sva #(.FRAME_LEN(FRAME_LEN)) vcsp_serial_port_sva_inst (
  .CLK(CLK), .SRST(SRST), .MCLK(MCLK), .RX_BIT_CLOCK(RX_BIT_CLOCK),
  .RX_FRAME_SYNC(RX_FRAME_SYNC), .TX_FRAME_SYNC(TX_FRAME_SYNC), .LINEAR_SELECT_N(LINEAR_SELECT_N),
  .DOUT(DOUT), .DOUT_OE(DOUT_OE), .TX_SLOT_STROBE_N_O(TX_SLOT_STROBE_N_O),
  .TX_SLOT_STROBE_N_OE(TX_SLOT_STROBE_N_OE), .TX_WORD(TX_WORD), .TX_TAKE(TX_TAKE),
  .RX_WORD(RX_WORD), .RX_VALID(RX_VALID), .LINEAR_MODE(LINEAR_MODE), .FIXED_MODE(FIXED_MODE),
  .RX_STANDBY(RX_STANDBY), .TEST_MODE(TEST_MODE));

// ==== vcsp_host_model.sv ====
`timescale 1ns/10ps
module vcsp_host_model #(
  parameter real MCLK_HALF = 244.0  // About 2.048 MHz
) (
  // Mode and shared pin
  input  wire logic fixed,
  input  wire logic strobe_o,
  input  wire logic strobe_oe,
  // Pins towards the device
  output logic      mclk,
  output logic      rx_clk,
  output logic      tx_clk,
  output logic      rx_fs,
  output logic      tx_fs,
  output logic      din,
  // Device transmit line
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic vclk;  // Variable bit clock, stands low between slots
  logic run;   // Keeps the variable clock going
  wire  bclk = fixed ? mclk : vclk;
  initial begin
    run  = 1'b0;
    din  = 1'b0;
    hold(1'b0);
  end
  // Master clock runs free; one process owns it
  initial begin
    mclk = 1'b0;
    forever #(MCLK_HALF) mclk = ~mclk;
  end
  // Finishes a started period so the clock always rests low
  initial begin
    vclk = 1'b0;
    forever #62.5 if (run || vclk) vclk = ~vclk;
  end
  assign rx_clk = fixed | vclk;
  // Open-drain pin with pull-up while fixed
  assign tx_clk = fixed ? (strobe_oe ? strobe_o : 1'b1) : vclk;
  task automatic hold(input logic v);
    rx_fs = v;
    tx_fs = v;
  endtask
  // One slot each way; DIN moves after rises, far from sampling falls
  task automatic xfer(input int n, input logic [15:0] to_dev, output logic [15:0] from_dev);
    from_dev = '0;
    run = 1'b1;
    @(negedge bclk);
    @(posedge bclk);
    // Sync rises well clear of the rising edge just passed, so the device
    // cannot fold it into that edge and start one bit early
    #31 hold(1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      din = to_dev[i];
      @(posedge bclk);
      if (i < n - 1) from_dev = {from_dev[14:0], dout_oe ? dout : 1'bx};
      #2;
    end
    hold(1'b0);
    din = ~din;
    @(posedge bclk);
    from_dev = {from_dev[14:0], dout_oe ? dout : 1'bx};
    run = 1'b0;
  endtask
endmodule // vcsp_host_model

// ==== test_vcsp_serial_port.sv ====
`timescale 1ns/10ps
module test_vcsp_serial_port;
  import vcsp_pkg::*;
  localparam int FL = 32;  // Short frame keeps standby runs brief
  logic              clk, srst, lin_n, fixed;
  logic [WORD_W-1:0] tx_word, got, got_rx, tw, dw;
  logic [31:0]       seed;
  int                errors, samples_checked, nv, n0;
  wire               mclk, rx_clk, tx_clk, rx_fs, tx_fs, din, dout, dout_oe, stb_o, stb_oe;
  wire               take, rx_valid, linear, fixed_m, rx_sb, tx_sb, test_m;
  wire [WORD_W-1:0]  rx_word;
  vcsp_serial_port #(.FRAME_LEN(FL)) vcsp_serial_port_inst (
    .CLK(clk), .SRST(srst), .MCLK(mclk), .RX_BIT_CLOCK(rx_clk), .TX_BIT_CLOCK_I(tx_clk),
    .TX_SLOT_STROBE_N_O(stb_o), .TX_SLOT_STROBE_N_OE(stb_oe), .RX_FRAME_SYNC(rx_fs),
    .TX_FRAME_SYNC(tx_fs), .LINEAR_SELECT_N(lin_n), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe),
    .TX_WORD(tx_word), .TX_TAKE(take), .RX_WORD(rx_word), .RX_VALID(rx_valid),
    .LINEAR_MODE(linear), .FIXED_MODE(fixed_m), .RX_STANDBY(rx_sb), .TX_STANDBY(tx_sb),
    .TEST_MODE(test_m));
  vcsp_host_model vcsp_host_model_inst (
    .fixed(fixed), .strobe_o(stb_o), .strobe_oe(stb_oe), .mclk(mclk), .rx_clk(rx_clk),
    .tx_clk(tx_clk), .rx_fs(rx_fs), .tx_fs(tx_fs), .din(din), .dout(dout), .dout_oe(dout_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Companded words live in the low byte
  function automatic logic [15:0] exp_word(input logic lin, input logic [15:0] w);
    return lin ? w : {8'h00, w[7:0]};
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Count receive pulses and keep the word each one brings
  always @(posedge clk) if (rx_valid === 1'b1) begin
    nv++;
    got_rx = rx_word;
  end
  // Hang guard
  initial begin
    #600000;
    errors++;
    results();
  end
  initial begin
    srst    <= 1'b1;
    lin_n   <= 1'b0;
    fixed   <= 1'b0;
    tx_word <= 16'h0000;
    seed     = 32'hAB2D8B0F;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // Both codings in both rate modes; words go back to back
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      lin_n <= !m[0];
      fixed <= m[1];
      repeat (20) @(posedge mclk);
      check("linear mode", 16'(m[0]), 16'(linear));
      check("fixed mode", 16'(m[1]), 16'(fixed_m));
      for (int k = 0; k < 3; k++) begin
        seed = xs(seed);
        tw = k ? seed[15:0] : 16'h8001;
        dw = k ? seed[31:16] : 16'h7FFE;
        @(posedge clk);
        tx_word <= tw;
        n0 = nv;
        @(posedge clk);
        vcsp_host_model_inst.xfer(m[0] ? 16 : 8, dw, got);
        check("word on line", exp_word(m[0], tw), got);
        check("word received", exp_word(m[0], dw), got_rx);
        check("receive pulses", 16'(n0 + 1), 16'(nv));
      end
    end
    // Syncs idle low, then stuck high, each past five frames
    repeat (6 * FL + 8) @(posedge mclk);
    check("standby", 16'h0003, {14'h0000, rx_sb, tx_sb});
    vcsp_host_model_inst.hold(1'b1);
    repeat (6 * FL + 8) @(posedge mclk);
    check("test and standby", 16'h0004, {13'h0000, test_m, rx_sb, tx_sb});
    vcsp_host_model_inst.hold(1'b0);
    // Receive clock pin no longer tied high: back to variable rate
    @(posedge clk);
    fixed <= 1'b0;
    repeat (8) @(posedge clk);
    check("fixed mode", 16'h0000, 16'(fixed_m));
    results();
  end
endmodule // test_vcsp_serial_port
